// ### osasc_ctrl.sv
`timescale 1ns/100ps
`include "osasc_regs.svh"

// ---------------------------------------------------------------
// Result buffer
// ---------------------------------------------------------------
module osasc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data   = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
    end
  end

  // Flags are flopped so the upstream ready comes straight from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready  <= (count_next != DEPTH[AW:0]);
      out_valid <= (count_next != '0);
    end
  end
endmodule // osasc_fifo

// ---------------------------------------------------------------
// Serial interface and conversion sequencer
// ---------------------------------------------------------------
module osasc_ctrl (
  input  wire logic                             sys_clk,
  input  wire logic                             rst_n,
  input  wire logic                             cs_n,
  input  wire logic                             sclk,
  input  wire logic                             din,
  output logic                                  dout,
  output logic                                  dout_oe,
  output osasc_pkg::osasc_mode_t                conv_mode,
  output logic [2:0]                            chan_sel,
  output logic                                  conv_start,
  input  wire logic                             res_valid,
  output logic                                  res_ready,
  input  wire logic [`OSASC_RESULT_BITS-1:0]    res_data
);
  import osasc_pkg::*;

  osasc_pins_t                   pins_meta;
  osasc_pins_t                   pins_sync;
  osasc_pins_t                   pins_prev;
  osasc_mode_t                   mode_reg;
  logic [3:0]                    fe_cnt_reg;
  logic [3:0]                    re_cnt_reg;
  logic [`OSASC_CTRL_BITS-2:0]   ctrl_sr_reg;
  logic [2:0]                    next_ch_reg;
  logic [2:0]                    chan_sel_reg;
  logic [`OSASC_RESULT_BITS-1:0] res_sr_reg;
  logic                          dout_reg;
  logic                          dout_oe_reg;
  logic                          conv_start_reg;
  logic                          fe_evt;
  logic                          re_evt;
  logic                          cs_fall;
  logic                          pop;
  logic                          fifo_valid;
  logic [`OSASC_RESULT_BITS-1:0] fifo_data;
  logic [2:0]                    ctrl_addr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_meta <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      pins_sync <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      pins_prev <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    end else begin
      pins_meta <= '{cs_n: cs_n, sclk: sclk, din: din};
      pins_sync <= pins_meta;
      pins_prev <= pins_sync;
    end
  end

  // Chip select falling with clock low counts as a falling edge
  assign cs_fall = pins_prev.cs_n && !pins_sync.cs_n;
  assign fe_evt  = !pins_sync.cs_n &&
                   ((pins_prev.sclk && !pins_sync.sclk) ||
                    (cs_fall && !pins_sync.sclk));
  assign re_evt  = !pins_sync.cs_n && !pins_prev.sclk && pins_sync.sclk;
  assign pop     = fe_evt && (fe_cnt_reg == `OSASC_EDGE_DATA) && fifo_valid;
  assign ctrl_addr = ctrl_sr_reg[`OSASC_CH_HI-1:`OSASC_CH_LO-1];

  // ---------------------------------------------------------------
  // Edge counters
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fe_cnt_reg <= 4'h0;
      re_cnt_reg <= 4'h0;
    end else if (pins_sync.cs_n) begin
      fe_cnt_reg <= 4'h0;
      re_cnt_reg <= 4'h0;
    end else begin
      if (fe_evt) begin
        fe_cnt_reg <= fe_cnt_reg + 4'h1;
      end
      if (re_evt) begin
        re_cnt_reg <= re_cnt_reg + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Track / hold / power-down sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= ST_OFF;
    end else if (pins_sync.cs_n) begin
      mode_reg <= ST_OFF;
    end else if (fe_evt) begin
      case (mode_reg)
        ST_OFF: begin
          mode_reg <= ST_TRACK;
        end
        ST_TRACK: begin
          if (fe_cnt_reg == `OSASC_EDGE_HOLD) begin
            mode_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (fe_cnt_reg == `OSASC_EDGE_LAST) begin
            mode_reg <= ST_OFF;
          end
        end
        default: begin
          mode_reg <= ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= fe_evt && (fe_cnt_reg == `OSASC_EDGE_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // Control byte capture
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_sr_reg <= '0;
      next_ch_reg <= `OSASC_CH_RESET;
    end else if (re_evt && (re_cnt_reg <= `OSASC_RISE_LAST)) begin
      ctrl_sr_reg <= {ctrl_sr_reg[`OSASC_CTRL_BITS-3:0],
                      pins_sync.din};
      if (re_cnt_reg == `OSASC_RISE_LAST) begin
        // Only bits 5..3 are kept; the other five never reach logic
        next_ch_reg <= ctrl_addr;
      end
    end
  end

  // Address takes effect at the first fall of the next conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_sel_reg <= `OSASC_CH_RESET;
    end else if (fe_evt && (fe_cnt_reg == `OSASC_EDGE_FIRST)) begin
      chan_sel_reg <= next_ch_reg;
    end
  end

  // ---------------------------------------------------------------
  // Result shifter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg   <= 1'b0;
      res_sr_reg <= '0;
    end else if (fe_evt) begin
      if (fe_cnt_reg < `OSASC_EDGE_DATA) begin
        dout_reg <= 1'b0;
      end else if (fe_cnt_reg == `OSASC_EDGE_DATA) begin
        // An empty buffer yields zeros rather than a stale word
        dout_reg   <= fifo_valid && fifo_data[`OSASC_RESULT_BITS-1];
        res_sr_reg <= fifo_valid ? {fifo_data[`OSASC_RESULT_BITS-2:0], 1'b0}
                                 : '0;
      end else begin
        dout_reg   <= res_sr_reg[`OSASC_RESULT_BITS-1];
        res_sr_reg <= {res_sr_reg[`OSASC_RESULT_BITS-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_oe_reg <= 1'b0;
    end else begin
      dout_oe_reg <= !pins_sync.cs_n;
    end
  end

  osasc_fifo #(
    .WIDTH (`OSASC_RESULT_BITS),
    .DEPTH (`OSASC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   (res_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  assign dout       = dout_reg;
  assign dout_oe    = dout_oe_reg;
  assign conv_mode  = mode_reg;
  assign chan_sel   = chan_sel_reg;
  assign conv_start = conv_start_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_dout_tristate: assert property (
    pins_sync.cs_n |=> !dout_oe_reg)
    else $error("output enabled while chip select high");

  a_sclk_gated: assert property (
    pins_sync.cs_n && $past(pins_sync.cs_n) |->
      fe_cnt_reg == 4'h0 && re_cnt_reg == 4'h0 && mode_reg == ST_OFF)
    else $error("sequencer moved while deselected");

  a_track_first: assert property (
    fe_evt && fe_cnt_reg == `OSASC_EDGE_FIRST |=>
      mode_reg == ST_TRACK ##0 (mode_reg == ST_TRACK || cs_fall)[*1])
    else $error("no track on first fall");

  a_hold_fourth: assert property (
    fe_evt && fe_cnt_reg == `OSASC_EDGE_HOLD |=>
      mode_reg == ST_HOLD && conv_start_reg ##1 !conv_start_reg)
    else $error("hold not entered on fourth fall");

  a_lead_zero: assert property (
    fe_evt && fe_cnt_reg < `OSASC_EDGE_DATA |=> !dout_reg)
    else $error("leading bit not zero");

  a_cs_low_sclk: assert property (
    cs_fall && !pins_sync.sclk |=> mode_reg == ST_TRACK && fe_cnt_reg == 4'h1)
    else $error("select fall with clock low not a first fall");

  a_chan_next: assert property (
    re_evt && re_cnt_reg == `OSASC_RISE_LAST |=>
      next_ch_reg == $past(ctrl_addr))
    else $error("channel code not captured");

  a_chan_hold: assert property (
    re_evt && re_cnt_reg == `OSASC_RISE_LAST |=> $stable(chan_sel_reg))
    else $error("channel changed mid conversion");

  a_power_gap: assert property (
    fe_evt && fe_cnt_reg == `OSASC_EDGE_LAST |=> mode_reg == ST_OFF)
    else $error("no power-down after sixteenth fall");

endmodule // osasc_ctrl

// ### osasc_regs.svh
`ifndef OSASC_REGS_SVH
`define OSASC_REGS_SVH

`define OSASC_CTRL_BITS     8
`define OSASC_CH_HI         5
`define OSASC_CH_LO         3
`define OSASC_CH_RESET      3'h0
`define OSASC_RESULT_BITS   12
`define OSASC_FIFO_DEPTH    16
`define OSASC_EDGE_FIRST    4'h0
`define OSASC_EDGE_HOLD     4'h3
`define OSASC_EDGE_DATA     4'h4
`define OSASC_EDGE_LAST     4'hf
`define OSASC_RISE_LAST     4'h7

`endif

// ### osasc_pkg.sv
package osasc_pkg;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_TRACK = 2'b01,
    ST_HOLD  = 2'b10
  } osasc_mode_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } osasc_pins_t;

endpackage

// ### osasc_host.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Host model of the serial link
// ---------------------------------------------------------------
module osasc_host (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout_line
);
  logic [15:0] word_q [$];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // Clock pulses with select high; the device must not react
  task automatic idle_clk(input int n);
    repeat (n) begin
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
  endtask

  task automatic frame(input logic [7:0] ctl [16], input int n,
                       input bit low);
    logic [15:0] w;
    w = 16'h0000;
    if (low) begin
      sclk = 1'b0;
      #62.5;
    end
    cs_n = 1'b0;
    for (int i = 0; i < 16 * n; i++) begin
      if (!(low && i == 0)) begin
        #62.5 sclk = 1'b0;
      end
      // Bits after the byte are ignored, so keep them moving
      din = (i % 16 < 8) ? ctl[i / 16][7 - i % 16] : ~din;
      #62.5 sclk = 1'b1;
      w = {w[14:0], dout_line};
      if (i % 16 == 15) word_q.push_back(w);
    end
    #62.5 cs_n = 1'b1;
    // Released line must not keep showing the last bit
    din = ~din;
  endtask
endmodule // osasc_host

// ### osasc_ctrl_tb_top.sv
`timescale 1ns/100ps
module osasc_ctrl_tb_top;
  import osasc_pkg::*;
  logic        sys_clk, rst_n, res_valid, core_en;
  logic        dout, dout_oe, conv_start, res_ready;
  logic [11:0] res_data;
  logic [2:0]  chan_sel, exp_ch;
  logic [7:0]  conv_cnt;
  logic [7:0]  ctl [16];
  osasc_mode_t conv_mode;
  osasc_mode_t mode_q [$];
  wire         cs_n, sclk, din, dout_line;
  int          err_total, checks, exp_cnt;

  assign dout_line = dout_oe ? dout : 1'bz;

  osasc_host u_host (.cs_n(cs_n), .sclk(sclk), .din(din),
                     .dout_line(dout_line));

  osasc_ctrl DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
    .conv_mode(conv_mode), .chan_sel(chan_sel),
    .conv_start(conv_start), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Analog core stand-in: result tags channel and conversion count
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (core_en && res_valid && res_ready) res_valid <= #1 1'b0;
    if (core_en && conv_start) begin
      res_valid <= #1 1'b1;
      res_data  <= #1 {chan_sel, 1'b1, conv_cnt};
      conv_cnt  <= conv_cnt + 8'h01;
    end
  end

  always @(posedge sclk) if (!cs_n) mode_q.push_back(conv_mode);

  // ---------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------
  task automatic cmp_word(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp_mode(input osasc_mode_t got, exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Runs a frame, then judges words (only when core is set), modes and release of the pin
  task automatic run(input int n, input bit low, input bit core);
    osasc_mode_t em;
    mode_q.delete();
    u_host.frame(ctl, n, low);
    repeat (8) @(posedge sys_clk);
    #1 cmp_word({15'h0000, dout_oe}, 16'h0000, "oe idle");
    for (int k = 0; k < n; k++) begin
      if (core) begin
        cmp_word(u_host.word_q.pop_front(),
                 {4'h0, exp_ch, 1'b1, 8'(exp_cnt)}, "word");
        exp_cnt++;
      end
      exp_ch = ctl[k][5:3];
    end
    for (int i = 0; i < 16 * n; i++) begin
      em = (i % 16 < 3) ? ST_TRACK : (i % 16 < 15) ? ST_HOLD : ST_OFF;
      cmp_mode(mode_q[i], em, "mode");
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    cmp_word({12'h000, dout_oe, res_ready, conv_start, 1'b0}, 16'h0004,
             "reset flags");
    cmp_word({13'h0000, chan_sel}, 16'h0000, "reset chan");
    cmp_mode(conv_mode, ST_OFF, "reset mode");
    $display("test reset done");
  endtask

  task automatic t_gated();
    u_host.idle_clk(16);
    repeat (8) @(posedge sys_clk);
    #1 cmp_word({8'h00, conv_cnt}, 16'h0000, "gated conv");
    cmp_mode(conv_mode, ST_OFF, "gated mode");
    cmp_word({15'h0000, dout_oe}, 16'h0000, "gated oe");
    $display("test gated done");
  endtask

  task automatic t_first();
    ctl[0] = 8'hD7;
    run(1, 1'b0, 1'b1);
    $display("test first done");
  endtask

  task automatic t_multi();
    for (int k = 0; k < 8; k++) begin
      ctl[k] = {2'(k), 3'(k) ^ 3'h5, 3'(~k)};
    end
    run(8, 1'b1, 1'b1);
    $display("test multi done");
  endtask

  task automatic t_fifo();
    int t;
    core_en = 1'b0;
    res_valid = 1'b1;
    for (int k = 0; k < 16; k++) begin
      res_data = 12'hA00 + 12'(k);
      ctl[k] = 8'h00;
      t = 0;
      while (res_ready !== 1'b1 && t < 50) begin
        @(posedge sys_clk);
        #1 t++;
      end
      cmp_word({15'h0000, res_ready}, 16'h0001, "push ready");
      @(posedge sys_clk);
      #1;
    end
    res_data = 12'hBAD;
    repeat (4) @(posedge sys_clk);
    #1 cmp_word({15'h0000, res_ready}, 16'h0000, "full");
    res_valid = 1'b0;
    run(16, 1'b0, 1'b0);
    for (int k = 0; k < 16; k++) begin
      cmp_word(u_host.word_q.pop_front(), 16'h0A00 + 16'(k), "drain");
    end
    run(1, 1'b0, 1'b0);
    cmp_word(u_host.word_q.pop_front(), 16'h0000, "empty");
    cmp_word({15'h0000, res_ready}, 16'h0001, "ready");
    core_en = 1'b1;
    $display("test fifo done");
  endtask

  initial begin
    rst_n = 1'b0;
    res_valid = 1'b0;
    res_data = 12'h000;
    core_en = 1'b1;
    conv_cnt = 8'h00;
    exp_ch = 3'h0;
    err_total = 0;
    checks = 0;
    exp_cnt = 0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1 t_reset();
    t_gated();
    t_first();
    t_multi();
    t_fifo();
    results();
  end

  initial begin
    #400000;
    err_total++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end
endmodule // osasc_ctrl_tb_top
